// >>> hdl/port_pin_analog_select_mux.sv
// Purpose: port E pin muxing, analog select gating and config bits
// Assumes: peripheral outputs arrive on clk; pins are asynchronous
// Notes: all pin-side outputs are registered, one cycle of latency
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "port_pin_map.svh"
module port_pin_analog_select_mux #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] portEPinIn,
  output logic [2:0] portEPinOut,
  output logic [2:0] portEPinOeN,
  input wire logic portEPin3In,
  input wire logic [5:0] portBPinIn,
  input wire logic [7:2] portCPinIn,
  output logic [2:0] portEDigEn,
  output logic [5:0] portBDigEn,
  output logic [7:2] portCDigEn,
  input wire logic hvProgMode,
  input wire logic pwm3Active,
  input wire logic pwm3OutA,
  input wire logic pwm3OutB,
  input wire logic capComp3Active,
  input wire logic capComp3CompareOut,
  input wire logic capComp5Active,
  input wire logic capComp5CompareOut,
  output logic capComp3CaptureIn,
  output logic capComp5CaptureIn,
  output logic unit3AltRoute,
  output logic masterClearReq,
  output logic lowVoltProgEnable
);

  // Elaboration stops on an address too narrow for the register map
  if (ADDR_W < 6 || ADDR_W > 32) begin : gBadAddrW
    $error("ADDR_W must lie between 6 and 32");
  end

  // =====================================================================
  // Register file state
  port_pin_pkg::reg8_type portEDir_reg;
  port_pin_pkg::reg8_type portELatch_reg;
  port_pin_pkg::reg8_type portEAnalog_reg;
  port_pin_pkg::reg8_type port_b_analog_select_reg;
  port_pin_pkg::reg8_type portCAnalog_reg;
  port_pin_pkg::reg8_type config_byte3_high;
  port_pin_pkg::reg8_type config_byte4_low;
  logic [3:0] port_e_input_reg;
  logic [5:0] portBInput_reg;
  logic [7:0] portCInput_reg;

  // Bus front end wires
  logic regWr;
  logic [ADDR_W-1:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0] wrStrb;
  logic wrHit;
  logic [ADDR_W-1:0] rdAddr;
  logic [31:0] rdData;
  logic rdHit;

  // Synchronised pins
  logic [15:0] syncIn;
  logic [15:0] syncOut;
  logic [2:0] portESync;
  logic port_e_pin3;
  logic [5:0] port_b_pin;
  logic [7:2] portCSync;

  // Register match on word address, used by both read and write decode
  function automatic logic isReg(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
    isReg = (a[ADDR_W-1:2] == (ADDR_W-2)'(ofs[7:2]));
  endfunction

  axil_reg_slave #(
    .ADDR_W(ADDR_W)
  ) uBus (
    .clk(clk),
    .srst(srst),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .regWr(regWr),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrHit(wrHit),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdHit(rdHit)
  );

  // =====================================================================
  // Pin synchronisers: every pin input crosses in one bundle
  assign syncIn = {portCPinIn, portBPinIn, portEPin3In, portEPinIn};

  // Pin 3 resets high: a low idle would raise a clear request at reset
  pin_input_sync #(
    .WIDTH(16),
    .IDLE(`RST_PIN_SYNC)
  ) uSync (
    .clk(clk),
    .srst(srst),
    .pinIn(syncIn),
    .pinOut(syncOut)
  );

  assign portESync = syncOut[2:0];
  assign port_e_pin3 = syncOut[3];
  assign port_b_pin = syncOut[9:4];
  assign portCSync = syncOut[15:10];

  // =====================================================================
  // Write decode; only byte lane 0 carries register data
  logic lane0;
  logic wrEDir;
  logic wrELatch;
  logic wrEAnalog;
  logic wrBAnalog;
  logic wrCAnalog;
  logic wrCfg3h;
  logic wrCfg4l;
  logic wrROnly;

  assign lane0 = regWr && wrStrb[0];
  assign wrEDir = lane0 && isReg(wrAddr, `OFS_E_DIR);
  assign wrELatch = lane0 && isReg(wrAddr, `OFS_E_LATCH);
  assign wrEAnalog = lane0 && isReg(wrAddr, `OFS_E_ANALOG);
  assign wrBAnalog = lane0 && isReg(wrAddr, `OFS_B_ANALOG);
  assign wrCAnalog = lane0 && isReg(wrAddr, `OFS_C_ANALOG);
  assign wrCfg3h = lane0 && isReg(wrAddr, `OFS_CFG3H);
  assign wrCfg4l = lane0 && hvProgMode && isReg(wrAddr, `OFS_CFG4L);
  // Input registers accept the write harmlessly
  assign wrROnly = isReg(wrAddr, `OFS_E_INPUT) ||
                   isReg(wrAddr, `OFS_B_INPUT) ||
                   isReg(wrAddr, `OFS_C_INPUT);
  assign wrHit = isReg(wrAddr, `OFS_E_DIR) ||
                 isReg(wrAddr, `OFS_E_LATCH) ||
                 isReg(wrAddr, `OFS_E_ANALOG) ||
                 isReg(wrAddr, `OFS_B_ANALOG) ||
                 isReg(wrAddr, `OFS_C_ANALOG) ||
                 isReg(wrAddr, `OFS_CFG3H) ||
                 isReg(wrAddr, `OFS_CFG4L) || wrROnly;

  // =====================================================================
  // Control registers; masks keep unimplemented bits at zero
  always_ff @(posedge clk) begin
    if (srst) begin
      portEDir_reg <= `RST_E_DIR;
      portELatch_reg <= `RST_E_LATCH;
      portEAnalog_reg <= `RST_E_ANALOG;
      port_b_analog_select_reg <= `RST_B_ANALOG;
      portCAnalog_reg <= `RST_C_ANALOG;
      config_byte3_high <= `RST_CFG3H;
      config_byte4_low <= `RST_CFG4L;
    end else begin
      if (wrEDir) begin
        portEDir_reg <= wrData[7:0] & `MASK_E_CTRL;
      end
      if (wrELatch) begin
        portELatch_reg <= wrData[7:0] & `MASK_E_CTRL;
      end
      if (wrEAnalog) begin
        portEAnalog_reg <= wrData[7:0] & `MASK_E_CTRL;
      end
      if (wrBAnalog) begin
        port_b_analog_select_reg <= wrData[7:0] & `MASK_B_ANALOG;
      end
      if (wrCAnalog) begin
        portCAnalog_reg <= wrData[7:0] & `MASK_C_ANALOG;
      end
      if (wrCfg3h) begin
        config_byte3_high <= wrData[7:0] & `MASK_CFG3H;
      end
      if (wrCfg4l) begin
        config_byte4_low <= wrData[7:0] & `MASK_CFG4L;
      end
    end
  end

  // =====================================================================
  // Named control fields
  logic [2:0] dirBit;
  logic [2:0] analogBit;
  logic [5:0] port_b_analog_bit;
  logic [7:2] port_c_analog_bit;
  logic reset_pin_enable;
  logic unit3_pin_select;
  logic [2:0] eDigIn;

  assign dirBit = portEDir_reg[2:0];
  assign analogBit = portEAnalog_reg[2:0];
  assign port_b_analog_bit = port_b_analog_select_reg[5:0];
  assign port_c_analog_bit = portCAnalog_reg[7:2];
  assign reset_pin_enable = config_byte3_high[`CFG3H_RST_PIN_EN_BIT];
  assign unit3_pin_select = config_byte3_high[`CFG3H_UNIT3_SEL_BIT];
  // digital input only when input and not analog
  assign eDigIn = dirBit & ~analogBit;

  // =====================================================================
  // Input registers; disabled buffers read as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      port_e_input_reg <= 4'h0;
      portBInput_reg <= 6'h00;
      portCInput_reg <= 8'h00;
    end else begin
      port_e_input_reg[2:0] <= portESync & eDigIn;
      port_e_input_reg[3] <= port_e_pin3 & ~reset_pin_enable;
      portBInput_reg <= port_b_pin & ~port_b_analog_bit;
      portCInput_reg <= {portCSync & ~port_c_analog_bit, 2'h0};
    end
  end

  // =====================================================================
  // Pin 0 driver source; PWM beats compare if both engines claim it
  port_pin_pkg::pin0_src_type pin0Src;
  logic unit3Here;
  logic pin0Drive;
  logic pin1Drive;
  logic pin2Drive;

  // pin 0 only with select clear
  assign unit3Here = !unit3_pin_select;
  assign pin0Src = (unit3Here && pwm3Active && !analogBit[0]) ?
                   port_pin_pkg::SRC_PWM :
                   (unit3Here && capComp3Active) ? port_pin_pkg::SRC_CCP :
                   port_pin_pkg::SRC_LATCH;

  always_comb begin
    unique case (pin0Src)
      port_pin_pkg::SRC_PWM: pin0Drive = pwm3OutA;
      port_pin_pkg::SRC_CCP: pin0Drive = capComp3CompareOut;
      port_pin_pkg::SRC_LATCH: pin0Drive = portELatch_reg[0];
    endcase
  end

  assign pin1Drive = (pwm3Active && !analogBit[1]) ? pwm3OutB :
                     portELatch_reg[1];
  assign pin2Drive = capComp5Active ? capComp5CompareOut : portELatch_reg[2];

  // =====================================================================
  // Registered pin drivers; enable low means the pin is driven
  always_ff @(posedge clk) begin
    if (srst) begin
      portEPinOut <= 3'h0;
      portEPinOeN <= 3'h7;
    end else begin
      portEPinOut <= {pin2Drive, pin1Drive, pin0Drive};
      portEPinOeN <= dirBit;
    end
  end

  // =====================================================================
  // Peripheral inputs, buffer enables and config outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      capComp3CaptureIn <= 1'b0;
      capComp5CaptureIn <= 1'b0;
      unit3AltRoute <= 1'b0;
      masterClearReq <= 1'b0;
      lowVoltProgEnable <= 1'b0;
      portEDigEn <= 3'h0;
      portBDigEn <= 6'h00;
      portCDigEn <= 6'h00;
    end else begin
      capComp3CaptureIn <= unit3Here && eDigIn[0] && portESync[0];
      capComp5CaptureIn <= eDigIn[2] && portESync[2];
      unit3AltRoute <= unit3_pin_select;
      masterClearReq <= reset_pin_enable && !port_e_pin3;
      lowVoltProgEnable <= config_byte4_low[`CFG4L_LV_PROG_BIT];
      portEDigEn <= ~analogBit;
      portBDigEn <= ~port_b_analog_bit;
      portCDigEn <= ~port_c_analog_bit;
    end
  end

  // =====================================================================
  // Read mux; unmapped words read zero with an error answer
  logic [7:0] rdByte;

  assign rdByte =
    isReg(rdAddr, `OFS_E_DIR) ? portEDir_reg :
    isReg(rdAddr, `OFS_E_LATCH) ? portELatch_reg :
    isReg(rdAddr, `OFS_E_ANALOG) ? portEAnalog_reg :
    isReg(rdAddr, `OFS_E_INPUT) ? {4'h0, port_e_input_reg} :
    isReg(rdAddr, `OFS_B_ANALOG) ? port_b_analog_select_reg :
    isReg(rdAddr, `OFS_C_ANALOG) ? portCAnalog_reg :
    isReg(rdAddr, `OFS_CFG3H) ? config_byte3_high :
    isReg(rdAddr, `OFS_CFG4L) ? config_byte4_low :
    isReg(rdAddr, `OFS_B_INPUT) ? {2'h0, portBInput_reg} :
    isReg(rdAddr, `OFS_C_INPUT) ? portCInput_reg : 8'h00;

  assign rdHit = isReg(rdAddr, `OFS_E_DIR) ||
                 isReg(rdAddr, `OFS_E_LATCH) ||
                 isReg(rdAddr, `OFS_E_ANALOG) ||
                 isReg(rdAddr, `OFS_E_INPUT) ||
                 isReg(rdAddr, `OFS_B_ANALOG) ||
                 isReg(rdAddr, `OFS_C_ANALOG) ||
                 isReg(rdAddr, `OFS_CFG3H) ||
                 isReg(rdAddr, `OFS_CFG4L) ||
                 isReg(rdAddr, `OFS_B_INPUT) ||
                 isReg(rdAddr, `OFS_C_INPUT);
  assign rdData = {24'h000000, rdByte};

endmodule

// >>> common/port_pin_map.svh
// Purpose: offsets, field positions, masks and reset values of port slice
// Assumes: byte addresses on a 32-bit AXI4-Lite bus, one word per register
// Notes: registers are 8 bits wide in the low byte lane
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH

// =====================================================================
// Register byte offsets
`define OFS_E_DIR 8'h00
`define OFS_E_LATCH 8'h04
`define OFS_E_ANALOG 8'h08
`define OFS_E_INPUT 8'h0C
`define OFS_B_ANALOG 8'h10
`define OFS_C_ANALOG 8'h14
`define OFS_CFG3H 8'h18
`define OFS_CFG4L 8'h1C
`define OFS_B_INPUT 8'h20
`define OFS_C_INPUT 8'h24

// =====================================================================
// Field positions
`define CFG3H_RST_PIN_EN_BIT 7
`define CFG3H_UNIT3_SEL_BIT 2
`define CFG4L_LV_PROG_BIT 2

// =====================================================================
// Implemented-bit masks
`define MASK_E_CTRL 8'h07
`define MASK_B_ANALOG 8'h3F
`define MASK_C_ANALOG 8'hFC
`define MASK_CFG3H 8'h84
`define MASK_CFG4L 8'h04

// =====================================================================
// Reset values
`define RST_E_DIR 8'h07
`define RST_E_LATCH 8'h00
`define RST_E_ANALOG 8'h07
`define RST_B_ANALOG 8'h3F
`define RST_C_ANALOG 8'hFC
`define RST_CFG3H 8'h84
`define RST_CFG4L 8'h04

// =====================================================================
// Synchroniser reset levels: pin 3 rests high, the reset pin's idle level
`define RST_PIN_SYNC 16'h0008

`endif

// >>> common/port_pin_pkg.sv
// Purpose: shared types of the port slice
// Assumes: nothing beyond SystemVerilog packages
// Notes: constants live in port_pin_map.svh
package port_pin_pkg;

  // =====================================================================
  // Bus answer codes
  typedef enum logic [1:0] {
    RESP_OKAY = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_type;

  // =====================================================================
  // Source of the pin 0 output driver
  typedef enum logic [2:0] {
    SRC_LATCH = 3'h1,
    SRC_PWM = 3'h2,
    SRC_CCP = 3'h4
  } pin0_src_type;

  typedef logic [7:0] reg8_type;

endpackage

// >>> hdl/pin_input_sync.sv
// Purpose: three-flop synchroniser with agreement filter for pin inputs
// Assumes: inputs asynchronous to clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_input_sync #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // Elaboration stops on an empty bundle
  if (WIDTH < 1) begin : gBadWidth
    $error("pin_input_sync needs WIDTH of at least 1");
  end

  // =====================================================================
  // Stage one feeds only stage two, so metastability stays contained
  always_ff @(posedge clk) begin
    if (srst) begin
      // Idle levels, so no false edge follows reset
      stage1_reg <= IDLE;
      stage2_reg <= IDLE;
      stage3_reg <= IDLE;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Per bit: take the new level only once two stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : gBit
      always_ff @(posedge clk) begin
        if (srst) begin
          pinOut[i] <= IDLE[i];
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          pinOut[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate

endmodule

// >>> hdl/axil_reg_slave.sv
// Purpose: AXI4-Lite slave front end, one write and one read at a time
// Assumes: register file answers rdData and hits combinationally
// Notes: write pulse one cycle after both channels are held
`timescale 1ns/1ps
module axil_reg_slave #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic regWr,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrHit,
  output logic [ADDR_W-1:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdHit
);

  logic rdStage_reg;

  // Both channels held and no answer pending: one write pulse
  assign regWr = !awready && !wready && !bvalid;

  // =====================================================================
  // Write address and data, taken in either order
  always_ff @(posedge clk) begin
    if (srst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= port_pin_pkg::RESP_OKAY;
      wrAddr <= '0;
      wrData <= '0;
      wrStrb <= '0;
    end else begin
      if (awvalid && awready) begin
        wrAddr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wrData <= wdata;
        wrStrb <= wstrb;
        wready <= 1'b0;
      end
      if (regWr) begin
        bvalid <= 1'b1;
        bresp <= wrHit ? port_pin_pkg::RESP_OKAY : port_pin_pkg::RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Read: address captured, data sampled one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= port_pin_pkg::RESP_OKAY;
      rdAddr <= '0;
      rdStage_reg <= 1'b0;
    end else begin
      if (arvalid && arready) begin
        rdAddr <= araddr;
        arready <= 1'b0;
        rdStage_reg <= 1'b1;
      end
      if (rdStage_reg) begin
        rdStage_reg <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdData;
        rresp <= rdHit ? port_pin_pkg::RESP_OKAY : port_pin_pkg::RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// >>> test/port_pin_checker.sv
// Purpose: port-level relations of the port slice
// Assumes: one clock domain, srst synchronous active high
// Notes: bound to the top module below
`timescale 1ns/1ps
module port_pin_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic [31:0] rdata,
  input wire logic [2:0] portEPinIn,
  input wire logic [2:0] portEPinOut,
  input wire logic [2:0] portEPinOeN,
  input wire logic portEPin3In,
  input wire logic [2:0] portEDigEn,
  input wire logic [7:2] portCDigEn,
  input wire logic pwm3Active,
  input wire logic pwm3OutB,
  input wire logic capComp5Active,
  input wire logic capComp5CompareOut,
  input wire logic capComp3CaptureIn,
  input wire logic capComp5CaptureIn,
  input wire logic unit3AltRoute,
  input wire logic masterClearReq
);
  // =====================================================================
  // Relations
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Bus answers come within two edges; a write blocks a second one
  read_lat_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read answer late");
  write_lat_a: assert property (awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid) else $error("write answer late");
  aw_block_a: assert property (awvalid && awready |=> !awready)
    else $error("second write address taken");
  rd_width_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  clr_idle_a: assert property (portEPin3In [*8] |=> !masterClearReq)
    else $error("reset request with pin high");
  cap5_low_a: assert property (!portEPinIn[2] [*8]
    |=> !capComp5CaptureIn) else $error("capture five without pin");
  pwm_b_a: assert property (pwm3Active && !portEPinOeN[1]
    && portEDigEn[1] ##1 !portEPinOeN[1] && portEDigEn[1]
    |-> portEPinOut[1] == $past(pwm3OutB)) else $error("pwm B not routed");
  cmp5_out_a: assert property (capComp5Active && !portEPinOeN[2]
    ##1 !portEPinOeN[2] |-> portEPinOut[2] == $past(capComp5CompareOut))
    else $error("compare five not routed");
  alt_route_a: assert property (unit3AltRoute [*2]
    |-> !capComp3CaptureIn) else $error("capture three while rerouted");
  c_reset_a: assert property ($fell(srst) |-> portCDigEn == 6'h00)
    else $error("port C buffers on after reset");
endmodule

bind port_pin_analog_select_mux port_pin_checker chk (.clk, .srst,
  .awvalid, .awready, .wvalid, .wready, .bvalid, .arvalid, .arready,
  .rvalid, .rdata, .portEPinIn, .portEPinOut, .portEPinOeN, .portEPin3In,
  .portEDigEn, .portCDigEn, .pwm3Active, .pwm3OutB, .capComp5Active,
  .capComp5CompareOut, .capComp3CaptureIn, .capComp5CaptureIn,
  .unit3AltRoute, .masterClearReq);

// >>> test/port_pin_board_model.sv
// Purpose: board side of the port E pins
// Assumes: the board drives every pin weakly
// Notes: a driving device overrides the board level
`timescale 1ns/1ps
module port_pin_board_model (
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOeN,
  input wire logic [2:0] boardLevel,
  output logic [2:0] pinIn
);
  assign pinIn = (pinOeN & boardLevel) | (~pinOeN & pinOut);
endmodule

// >>> test/port_pin_analog_select_mux_tb.sv
// Purpose: register and pin scenarios of the port slice
// Assumes: AXI4-Lite master, one transfer at a time
// Notes: pin inputs settle in four cycles through the synchroniser; the bench waits eight
`timescale 1ns/1ps
`include "port_pin_map.svh"
module port_pin_analog_select_mux_tb;
  logic clk = 1'b0, srst = 1'b1, hv = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, pin3 = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, cap3, cap5, alt;
  logic clrReq, lvProg;
  logic pwmAct = 1'b0, pwmA = 1'b0, pwmB = 1'b0, c3Act = 1'b0, c3Out = 1'b0;
  logic c5Act = 1'b0, c5Out = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, r;
  logic [2:0] boardE = 3'h7, pinIn, pinOut, oeN, digE;
  logic [5:0] pinB = 6'h3F, digB;
  logic [7:2] pinC = 6'h3F, digC;
  logic [31:0] d;
  int err_count = 0, cmp_count = 0;
  logic [7:0] ofsTab [7] = '{`OFS_E_DIR, `OFS_E_LATCH, `OFS_E_ANALOG,
    `OFS_B_ANALOG, `OFS_C_ANALOG, `OFS_CFG3H, `OFS_CFG4L};
  logic [7:0] rstTab [7] = '{8'h07, 8'h00, 8'h07, 8'h3F, 8'hFC, 8'h84, 8'h04};

  always #2 clk = ~clk;

  port_pin_board_model board (.pinOut(pinOut), .pinOeN(oeN),
    .boardLevel(boardE), .pinIn(pinIn));
  port_pin_analog_select_mux #(.ADDR_W(8)) dut (.clk(clk), .srst(srst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .portEPinIn(pinIn), .portEPinOut(pinOut),
    .portEPinOeN(oeN), .portEPin3In(pin3), .portBPinIn(pinB),
    .portCPinIn(pinC), .portEDigEn(digE), .portBDigEn(digB),
    .portCDigEn(digC), .hvProgMode(hv), .pwm3Active(pwmAct),
    .pwm3OutA(pwmA), .pwm3OutB(pwmB), .capComp3Active(c3Act),
    .capComp3CompareOut(c3Out), .capComp5Active(c5Act),
    .capComp5CompareOut(c5Out), .capComp3CaptureIn(cap3),
    .capComp5CaptureIn(cap5), .unit3AltRoute(alt),
    .masterClearReq(clrReq), .lowVoltProgEnable(lvProg));

  // =====================================================================
  // Checking and closing
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded waits; a hang ends the run as a failure
  task automatic hang(input int n);
    if (n == 50) begin
      err_count++;
      $display("mismatch at %0t: no bus answer", $time);
      wrap_up();
    end
  endtask

  // =====================================================================
  // Bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    // Idle edge: a next call must not reassign bready in this step
    @(posedge clk);
    hang(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    // Idle edge also lets outputs launched at the answer edge settle
    @(posedge clk);
    hang(n);
  endtask

  task automatic wo(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    chk(32'(r), 32'(port_pin_pkg::RESP_OKAY));
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(32'(r), 32'(port_pin_pkg::RESP_OKAY));
    chk(d, e);
  endtask

  // =====================================================================
  // Scenarios
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) rc(ofsTab[i], 32'(rstTab[i]));
    wo(`OFS_B_ANALOG, 32'hFF);
    rc(`OFS_B_ANALOG, 32'h3F);
    wo(`OFS_B_ANALOG, 32'hD5);
    rc(`OFS_B_ANALOG, 32'h15);
    chk(32'(digB), 32'h2A);
    rc(`OFS_B_INPUT, 32'h2A);
    wo(`OFS_C_ANALOG, 32'hF3);
    rc(`OFS_C_ANALOG, 32'hF0);
    chk(32'(digC), 32'h03);
    rc(`OFS_C_INPUT, 32'h0C);
    wr(8'h30, 32'h1);
    chk(32'(r), 32'(port_pin_pkg::RESP_SLVERR));
    rd(8'h30);
    chk(32'(r), 32'(port_pin_pkg::RESP_SLVERR));
    chk(d, 32'h0);
    wo(`OFS_CFG4L, 32'h0);
    rc(`OFS_CFG4L, 32'h04);
    chk(32'(lvProg), 32'h1);
    hv <= 1'b1;
    wo(`OFS_CFG4L, 32'h0);
    rc(`OFS_CFG4L, 32'h00);
    chk(32'(lvProg), 32'h0);
    hv <= 1'b0;
    // Outputs follow the latch even with analog selected
    wo(`OFS_E_LATCH, 32'h05);
    wo(`OFS_E_DIR, 32'h00);
    repeat (2) @(posedge clk);
    chk(32'({oeN, pinOut}), 32'h05);
    wo(`OFS_CFG3H, 32'h80);
    wo(`OFS_E_ANALOG, 32'h00);
    pwmAct <= 1'b1;
    pwmB <= 1'b1;
    c5Act <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(pinOut), 32'h2);
    wo(`OFS_CFG3H, 32'h84);
    chk(32'({alt, pinOut}), 32'hB);
    wo(`OFS_CFG3H, 32'h80);
    pwmAct <= 1'b0;
    c3Act <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(pinOut), 32'h0);
    // Inputs through the synchroniser
    wo(`OFS_E_DIR, 32'h07);
    wo(`OFS_E_ANALOG, 32'h02);
    chk(32'(digE), 32'h5);
    wo(`OFS_CFG3H, 32'h00);
    repeat (8) @(posedge clk);
    rc(`OFS_E_INPUT, 32'h0D);
    chk(32'({cap3, cap5}), 32'h3);
    wo(`OFS_CFG3H, 32'h80);
    rc(`OFS_E_INPUT, 32'h05);
    pin3 <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'(clrReq), 32'h1);
    wo(`OFS_CFG3H, 32'h00);
    repeat (2) @(posedge clk);
    chk(32'(clrReq), 32'h0);
    wrap_up();
  end
endmodule
